// File: rtl/sysref_clock_pkg.sv
// Constants shared by the clock and sync input control block
package sysref_clock_pkg;
  // ==========================================================
  // Register offsets on the register port
  localparam logic [7:0] ADDR_CLOCK_CONTROL_0 = 8'h29;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_1 = 8'h2A;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_2 = 8'h2B;
  localparam logic [7:0] ADDR_POSITION_BYTE0  = 8'h2C;
  localparam logic [7:0] ADDR_POSITION_BYTE1  = 8'h2D;
  localparam logic [7:0] ADDR_POSITION_BYTE2  = 8'h2E;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RESET_CLOCK_CONTROL_0 = 8'h80;
  localparam logic [7:0]  RESET_CLOCK_CONTROL_1 = 8'h00;
  localparam logic [7:0]  RESET_CLOCK_CONTROL_2 = 8'h10;
  localparam logic [23:0] RESET_POSITION        = 24'h000000;

  // ==========================================================
  // Field positions
  localparam int BIT_PROCESSOR_ENABLE = 6;
  localparam int BIT_RECEIVER_ENABLE  = 5;
  localparam int BIT_FINE_STEP        = 4;
  localparam int SEL_MSB              = 3;
  localparam int SEL_LSB              = 0;
  localparam int BIT_DEVCLOCK_PECL    = 2;
  localparam int BIT_SYNC_PECL        = 1;
  localparam int BIT_POLARITY_INVERT  = 0;
  localparam int BIT_ANALOG_QUIET     = 2;
  localparam int BIT_RAIL_QUIET       = 0;

  // ==========================================================
  // Delay line geometry
  localparam int POSITION_WIDTH = 24;
  localparam int DELAY_DEPTH    = 48;
endpackage

// File: rtl/sync_path_if.sv
// Configuration and status carried between the register file and the sync path
interface sync_path_if;
  logic        receiver_enable;
  logic        processor_enable;
  logic        fine_step;
  logic [3:0]  delay_select;
  logic        polarity_invert;
  logic        sync_event;
  logic [23:0] position;

  modport ctrl (
    output receiver_enable,
    output processor_enable,
    output fine_step,
    output delay_select,
    output polarity_invert,
    input  sync_event,
    input  position
  );

  modport path (
    input  receiver_enable,
    input  processor_enable,
    input  fine_step,
    input  delay_select,
    input  polarity_invert,
    output sync_event,
    output position
  );
endinterface

// File: rtl/sync_path.sv
// Sync input path: receiver gate, inversion, delay tap selection and edge position capture
module sync_path (
  input wire logic   core_clk,
  input wire logic   rst_n,
  input wire logic   sync_in,
  sync_path_if.path  cfg
);
  localparam int D = sysref_clock_pkg::DELAY_DEPTH;
  localparam int P = sysref_clock_pkg::POSITION_WIDTH;

  logic [D-1:0] line_reg;
  logic         tapped_d_reg;
  logic         sync_event_reg;
  logic [P-1:0] position_reg;
  logic         aligned;
  logic [4:0]   tap;
  logic         tapped;
  logic [P-1:0] coarse_view;

  // =========================================================
  // Receiver gate and polarity
  // A disabled receiver presents the polarity_invert level, so no edge appears unless that bit changes
  assign aligned = (sync_in & cfg.receiver_enable) ^ cfg.polarity_invert;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_reg <= '0;
    end else begin
      line_reg <= {line_reg[D-2:0], aligned};
    end
  end

  // =========================================================
  // Delay tap: fine steps are one sample, coarse steps are two
  assign tap    = cfg.fine_step ? {1'b0, cfg.delay_select}
                                : {cfg.delay_select, 1'b0};
  assign tapped = line_reg[tap];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tapped_d_reg   <= 1'b0;
      sync_event_reg <= 1'b0;
    end else begin
      tapped_d_reg   <= tapped;
      sync_event_reg <= cfg.processor_enable & tapped & ~tapped_d_reg;
    end
  end

  // =========================================================
  // Edge position: snapshot of the line when a fresh edge enters it
  generate
    for (genvar i = 0; i < P; i++) begin : g_coarse
      assign coarse_view[i] = line_reg[2*i];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      position_reg <= sysref_clock_pkg::RESET_POSITION;
    end else if (cfg.receiver_enable && line_reg[0] && !line_reg[1]) begin
      position_reg <= cfg.fine_step ? line_reg[P-1:0] : coarse_view;
    end
  end

  assign cfg.sync_event = sync_event_reg;
  assign cfg.position   = position_reg;

  // =========================================================
  // Checks
  event_needs_processor_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sync_event_reg |-> $past(cfg.processor_enable))
    else $error("sync event while processor disabled");

  event_at_tap_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sync_event_reg |-> $past(tapped) && !$past(tapped_d_reg))
    else $error("sync event without rising edge at tap");

  receiver_off_quiet_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!cfg.receiver_enable && !cfg.polarity_invert)[*2] |=> !line_reg[0])
    else $error("line sampled while receiver disabled");

  event_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n) sync_event_reg);
  fine_event_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    cfg.fine_step && sync_event_reg);
endmodule

// File: rtl/sysref_clock_input_control.sv
// Clock and sync input control registers with the sync processing path
// =============================================================
module sysref_clock_input_control (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       sync_in,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            sync_event,
  output logic            sync_receiver_enable,
  output logic            devclock_pecl_input_mode,
  output logic            sync_pecl_input_mode,
  output logic            analog_clock_supply_quiet_enable,
  output logic            clock_rail_quiet_enable
);
  logic [7:0] clock_control_0_reg;
  logic [7:0] clock_control_1_reg;
  logic [7:0] clock_control_2_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  sync_path_if link ();

  // Strobe qualified by one register address; shared by the write decode and the checks
  function automatic logic bus_hit(
    input logic       strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && (addr == target);
  endfunction

  // =========================================================
  // Writable control registers
  // Reserved bits are stored as written; keeping defaults is software's job
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_control_0_reg <= sysref_clock_pkg::RESET_CLOCK_CONTROL_0;
    end else if (bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_0)) begin
      clock_control_0_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_control_1_reg <= sysref_clock_pkg::RESET_CLOCK_CONTROL_1;
    end else if (bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_1)) begin
      clock_control_1_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_control_2_reg <= sysref_clock_pkg::RESET_CLOCK_CONTROL_2;
    end else if (bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_2)) begin
      clock_control_2_reg <= reg_wdata;
    end
  end

  // =========================================================
  // Read path; the position bytes have no write decode at all
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      sysref_clock_pkg::ADDR_CLOCK_CONTROL_0: rdata_next = clock_control_0_reg;
      sysref_clock_pkg::ADDR_CLOCK_CONTROL_1: rdata_next = clock_control_1_reg;
      sysref_clock_pkg::ADDR_CLOCK_CONTROL_2: rdata_next = clock_control_2_reg;
      sysref_clock_pkg::ADDR_POSITION_BYTE0:  rdata_next = link.position[7:0];
      sysref_clock_pkg::ADDR_POSITION_BYTE1:  rdata_next = link.position[15:8];
      sysref_clock_pkg::ADDR_POSITION_BYTE2:  rdata_next = link.position[23:16];
      default:                                rdata_next = 8'h00;
    endcase
  end

  // Read data holds its value until the next read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_reg <= rdata_next;
    end
  end

  // =========================================================
  // Configuration to the sync path
  assign link.processor_enable =
    clock_control_0_reg[sysref_clock_pkg::BIT_PROCESSOR_ENABLE];
  assign link.receiver_enable  =
    clock_control_0_reg[sysref_clock_pkg::BIT_RECEIVER_ENABLE];
  assign link.fine_step        =
    clock_control_0_reg[sysref_clock_pkg::BIT_FINE_STEP];
  assign link.delay_select     =
    clock_control_0_reg[sysref_clock_pkg::SEL_MSB:sysref_clock_pkg::SEL_LSB];
  assign link.polarity_invert  =
    clock_control_1_reg[sysref_clock_pkg::BIT_POLARITY_INVERT];

  sync_path u_sync_path (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sync_in  (sync_in),
    .cfg      (link.path)
  );

  // =========================================================
  // Outputs, all taken from register bits except sync_event, which comes from the sync path
  assign reg_rdata                        = rdata_reg;
  assign sync_event                       = link.sync_event;
  assign sync_receiver_enable             = link.receiver_enable;
  assign devclock_pecl_input_mode         =
    clock_control_1_reg[sysref_clock_pkg::BIT_DEVCLOCK_PECL];
  assign sync_pecl_input_mode             =
    clock_control_1_reg[sysref_clock_pkg::BIT_SYNC_PECL];
  assign analog_clock_supply_quiet_enable =
    clock_control_2_reg[sysref_clock_pkg::BIT_ANALOG_QUIET];
  assign clock_rail_quiet_enable          =
    clock_control_2_reg[sysref_clock_pkg::BIT_RAIL_QUIET];

  // =========================================================
  // Checks
  ctrl0_write_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_0)
    |=> clock_control_0_reg == $past(reg_wdata))
    else $error("clock control 0 write not taken");

  receiver_write_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_0)
    |=> sync_receiver_enable == $past(reg_wdata[sysref_clock_pkg::BIT_RECEIVER_ENABLE]))
    else $error("receiver enable does not follow write");

  fine_step_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_0)
    |=> link.fine_step == $past(reg_wdata[sysref_clock_pkg::BIT_FINE_STEP]))
    else $error("fine step does not follow write");

  delay_select_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_0)
    |=> link.delay_select ==
        $past(reg_wdata[sysref_clock_pkg::SEL_MSB:sysref_clock_pkg::SEL_LSB]))
    else $error("delay select does not follow write");

  polarity_write_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_1)
    |=> link.polarity_invert == $past(reg_wdata[sysref_clock_pkg::BIT_POLARITY_INVERT]))
    else $error("polarity invert does not follow write");

  no_event_disabled_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!link.processor_enable)[*2] |-> !sync_event)
    else $error("sync event while processing disabled");

  position_low_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_rd_en, reg_addr, sysref_clock_pkg::ADDR_POSITION_BYTE0)
    |=> reg_rdata == $past(link.position[7:0]))
    else $error("position low byte read mismatch");

  position_mid_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_rd_en, reg_addr, sysref_clock_pkg::ADDR_POSITION_BYTE1)
    |=> reg_rdata == $past(link.position[15:8]))
    else $error("position middle byte read mismatch");

  position_read_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_rd_en, reg_addr, sysref_clock_pkg::ADDR_POSITION_BYTE2)
    |=> reg_rdata == $past(link.position[23:16]))
    else $error("position byte read mismatch");

  position_readonly_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_POSITION_BYTE0)
    |=> $stable(clock_control_0_reg) && $stable(clock_control_1_reg)
        && $stable(clock_control_2_reg))
    else $error("position write disturbed a control register");

  read_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read strobe");

  unmapped_read_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd_en && (reg_addr < sysref_clock_pkg::ADDR_CLOCK_CONTROL_0
                  || reg_addr > sysref_clock_pkg::ADDR_POSITION_BYTE2)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");

  pecl_mode_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_1)
    |=> devclock_pecl_input_mode == $past(reg_wdata[sysref_clock_pkg::BIT_DEVCLOCK_PECL])
        && sync_pecl_input_mode == $past(reg_wdata[sysref_clock_pkg::BIT_SYNC_PECL]))
    else $error("pecl mode outputs do not follow write");

  quiet_enable_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_wr_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_2)
    |=> analog_clock_supply_quiet_enable ==
          $past(reg_wdata[sysref_clock_pkg::BIT_ANALOG_QUIET])
        && clock_rail_quiet_enable == $past(reg_wdata[sysref_clock_pkg::BIT_RAIL_QUIET]))
    else $error("quiet enables do not follow write");

  quiet_readback_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    bus_hit(reg_rd_en, reg_addr, sysref_clock_pkg::ADDR_CLOCK_CONTROL_2)
    |=> reg_rdata == $past(clock_control_2_reg))
    else $error("clock control 2 read mismatch");

  enable_order_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    link.receiver_enable && !link.processor_enable ##[1:20] link.processor_enable);
  position_read_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd_en && reg_addr == sysref_clock_pkg::ADDR_POSITION_BYTE0);
endmodule

// File: dv/sync_source_model.sv
// Behavioural model of the external sync pulse generator
module sync_source_model #(
  parameter int HIGH_CYCLES = 3
) (
  input  wire logic core_clk,
  input  wire logic fire,
  output logic      sync_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // Whole-period pulses followed by at least one low period, so edges never merge
  initial begin
    sync_in = 1'b0;
    forever begin
      @(posedge core_clk);
      if (fire === 1'b1) begin
        #10;
        sync_in = 1'b1;
        repeat (HIGH_CYCLES) @(posedge core_clk);
        #10;
        sync_in = 1'b0;
      end
    end
  end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the clock and sync input control registers
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic       core_clk;
  logic       rst_n;
  logic       sync_in;
  logic       fire;
  logic       reg_wr_en;
  logic       reg_rd_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       sync_event;
  logic       sync_receiver_enable;
  logic       devclock_pecl_input_mode;
  logic       sync_pecl_input_mode;
  logic       analog_clock_supply_quiet_enable;
  logic       clock_rail_quiet_enable;
  logic [7:0] modes;
  int         bad_count;
  int         tests_run;

  // Packed as {inv, fine, sel}
  localparam logic [5:0] CASES [6] = '{6'h00, 6'h05, 6'h0F, 6'h15, 6'h1F, 6'h33};

  assign modes = {2'h0, sync_event, sync_receiver_enable, devclock_pecl_input_mode,
                  sync_pecl_input_mode, analog_clock_supply_quiet_enable,
                  clock_rail_quiet_enable};

  sysref_clock_input_control sysref_clock_input_control_inst (
    .core_clk                         (core_clk),
    .rst_n                            (rst_n),
    .sync_in                          (sync_in),
    .reg_wr_en                        (reg_wr_en),
    .reg_rd_en                        (reg_rd_en),
    .reg_addr                         (reg_addr),
    .reg_wdata                        (reg_wdata),
    .reg_rdata                        (reg_rdata),
    .sync_event                       (sync_event),
    .sync_receiver_enable             (sync_receiver_enable),
    .devclock_pecl_input_mode         (devclock_pecl_input_mode),
    .sync_pecl_input_mode             (sync_pecl_input_mode),
    .analog_clock_supply_quiet_enable (analog_clock_supply_quiet_enable),
    .clock_rail_quiet_enable          (clock_rail_quiet_enable)
  );
  sync_source_model sync_source_model_inst (.core_clk(core_clk), .fire(fire), .sync_in(sync_in));

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr_en = 1'b1;
    @(posedge core_clk);
    #10;
    reg_wr_en = 1'b0;
    @(posedge core_clk);
    #10;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    reg_addr = addr;
    reg_rd_en = 1'b1;
    @(posedge core_clk);
    #10;
    reg_rd_en = 1'b0;
    chk(reg_rdata, exp, "register read");
    @(posedge core_clk);
    #10;
  endtask

  // Zero expected delay means no event may appear at all
  task automatic pulse(input int exp_n);
    int cnt;
    int first;
    cnt = 0;
    first = 0;
    fire = 1'b1;
    for (int n = 1; n <= 60; n++) begin
      @(posedge core_clk);
      #10;
      fire = 1'b0;
      if (sync_event === 1'b1) begin
        cnt++;
        if (first == 0) first = n;
      end
    end
    chk(8'(cnt), (exp_n == 0) ? 8'h00 : 8'h01, "event count");
    chk(8'(first), 8'(exp_n), "event delay");
  endtask

  // Settings change only with processing off, so no stray edge is aligned
  task automatic run_case(input logic [3:0] sel, input logic fine, input logic inv);
    logic [7:0] ctrl;
    int         tap;
    ctrl = {3'b101, fine, sel};
    tap = fine ? int'(sel) : 2 * int'(sel);
    wr(sysref_clock_pkg::ADDR_CLOCK_CONTROL_0, ctrl);
    wr(sysref_clock_pkg::ADDR_CLOCK_CONTROL_1, {7'h00, inv});
    repeat (50) @(posedge core_clk);
    #10;
    wr(sysref_clock_pkg::ADDR_CLOCK_CONTROL_0, ctrl | 8'h40);
    rd(sysref_clock_pkg::ADDR_CLOCK_CONTROL_0, ctrl | 8'h40);
    pulse(tap + 3 + (inv ? 3 : 0));
  endtask

  task automatic test_done;
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    fire = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    bad_count = 0;
    tests_run = 0;
    repeat (6) @(posedge core_clk);
    #10;
    rst_n = 1'b1;
    chk(modes, 8'h00, "outputs after reset");
    rd(sysref_clock_pkg::ADDR_CLOCK_CONTROL_0, 8'h80);
    rd(sysref_clock_pkg::ADDR_CLOCK_CONTROL_1, 8'h00);
    rd(sysref_clock_pkg::ADDR_CLOCK_CONTROL_2, 8'h10);
    wr(sysref_clock_pkg::ADDR_CLOCK_CONTROL_1, 8'h06);
    wr(sysref_clock_pkg::ADDR_CLOCK_CONTROL_2, 8'h15);
    chk(modes, 8'h0F, "input and quiet modes");
    rd(sysref_clock_pkg::ADDR_CLOCK_CONTROL_1, 8'h06);
    rd(sysref_clock_pkg::ADDR_CLOCK_CONTROL_2, 8'h15);
    wr(sysref_clock_pkg::ADDR_CLOCK_CONTROL_1, 8'h00);
    wr(sysref_clock_pkg::ADDR_CLOCK_CONTROL_2, 8'h10);
    chk(modes, 8'h00, "modes cleared");
    // Receiver first, processor still off
    wr(sysref_clock_pkg::ADDR_CLOCK_CONTROL_0, 8'hA0);
    chk(modes, 8'h10, "receiver only");
    pulse(0);
    wr(sysref_clock_pkg::ADDR_POSITION_BYTE0, 8'hFF);
    rd(sysref_clock_pkg::ADDR_POSITION_BYTE0, 8'h01);
    rd(sysref_clock_pkg::ADDR_POSITION_BYTE1, 8'h00);
    rd(sysref_clock_pkg::ADDR_POSITION_BYTE2, 8'h00);
    rd(8'h40, 8'h00);
    // Coarse and fine steps exercised, fine as software is advised at high rates
    for (int i = 0; i < 6; i++) begin
      run_case(CASES[i][3:0], CASES[i][4], CASES[i][5]);
    end
    test_done();
  end

  // Whole run is well under 2000 cycles
  initial begin
    #1000000;
    bad_count++;
    test_done();
  end
endmodule
